// ===== logic/can_cfg_pkg.sv
// constants for the can configuration block: sfr offsets, field positions, resets
// assumes an 8-bit special function register space with byte-wide registers
package can_cfg_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] OFS_PAGE = 8'hB1;
    localparam logic [7:0] OFS_BT_PRESCALE = 8'hB4;
    localparam logic [7:0] OFS_BT_JUMP_PROP = 8'hB5;
    localparam logic [7:0] OFS_BT_PHASE = 8'hB6;
    localparam logic [7:0] OFS_IE_HIGH = 8'hC2;
    localparam logic [7:0] OFS_IE_LOW = 8'hC3;

    // ****************************************
    // field positions
    // ****************************************
    localparam int PRESCALE_LSB = 1;
    localparam int PRESCALE_MSB = 6;
    localparam int JUMP_LSB = 5;
    localparam int JUMP_MSB = 6;
    localparam int PROP_LSB = 1;
    localparam int PROP_MSB = 3;
    localparam int PH2_LSB = 4;
    localparam int PH2_MSB = 6;
    localparam int PH1_LSB = 1;
    localparam int PH1_MSB = 3;
    localparam int TRIPLE_BIT = 0;
    localparam int OBJ_LSB = 4;
    localparam int OBJ_MSB = 7;
    localparam int AUTO_STEP_BIT = 3;
    localparam int PTR_LSB = 0;
    localparam int PTR_MSB = 2;
    localparam int IE_HIGH_MSB = 6;

    // ****************************************
    // writable masks and reset values
    // ****************************************
    localparam logic [7:0] MASK_BT_PRESCALE = 8'h7E;
    localparam logic [7:0] MASK_BT_JUMP_PROP = 8'h6E;
    localparam logic [7:0] MASK_BT_PHASE = 8'h7F;
    localparam logic [7:0] MASK_IE_HIGH = 8'h7F;
    localparam logic [7:0] RST_PAGE = 8'h00;
    localparam logic [7:0] RST_BT = 8'h00;
    localparam logic [7:0] RST_IE = 8'h00;

endpackage

// ===== logic/quantum_prescaler.sv
// time quantum divider: one quantum is (prescale + 1) clock periods
// assumes the controller clock is the can input clock
`timescale 1ns/10ps
module quantum_prescaler
    import can_cfg_pkg::*;
#(
    parameter int PW = 6
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [PW-1:0] prescale,
    // ticks
    output logic tq_tick_ff,
    output logic half_tick_ff
);

    logic [PW-1:0] cnt_ff;
    wire last_w = (cnt_ff == prescale);
    wire half_w = (cnt_ff == (prescale >> 1));
    wire [PW-1:0] nxt_cnt = last_w ? '0 : cnt_ff + 1'b1;

    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            cnt_ff <= '0;
            tq_tick_ff <= 1'b0;
            half_tick_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tq_tick_ff <= last_w;
            half_tick_ff <= half_w;
        end
    end

    a_tick_spacing: assert property (@(posedge clk) disable iff (rst || !run)
        (tq_tick_ff && run && $stable(prescale) && prescale == 1) |=> !tq_tick_ff ##1 tq_tick_ff)
        else $error("quantum tick not every prescale+1 clocks");

endmodule

// ===== logic/can_timing_config.sv
// Operation
// - each object has an enable bit gating its interrupt onto the controller interrupt
// - high enable byte holds objects 14..8 in bits 6-0; low byte objects 7..0
// - quantum equals prescale field plus one clock periods
// - bit timing resynchronises on the first falling bus edge after sync in each bit, stretching or shrinking the bit
// - jump width is field bits 6-5 plus one quanta per resynchronisation
// - propagation segment lasts field bits 3-1 plus one quanta
// - phase two lasts field bits 6-4 plus one quanta, shortened up to jump width
// - phase one lasts field bits 3-1 plus one quanta, lengthened up to jump width
// - triple sample bit selects single sample or majority of three half-quantum samples
// - page register: object number high, auto step bit, byte pointer low
// - object number selects which of objects 0..14 is accessed
// - auto step bit 0 advances the byte pointer per data access, 1 holds it
// - byte pointer names the data byte reached by the next data access
//
// can controller configuration: enable bits, bit timing and page select
// assumes byte-wide sfr strobes synchronous to clk and a synchronous bus receive level
`timescale 1ns/10ps
module can_timing_config
    import can_cfg_pkg::*;
#(
    parameter int NUM_OBJ = 15
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata_ff,
    // controller side
    input wire logic controller_on,
    input wire logic [NUM_OBJ-1:0] object_irq_pending,
    input wire logic data_access,
    output logic controller_irq_ff,
    output logic [3:0] object_number_ff,
    output logic [2:0] data_byte_pointer_ff,
    // bus side
    input wire logic can_rx,
    output logic sample_point_ff,
    output logic sampled_bit_ff,
    output logic bit_start_ff
);

    typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} seg_e;

    // ****************************************
    // register file
    // ****************************************
    logic [7:0] page_ff;
    logic [7:0] bt_prescale_ff;
    logic [7:0] bt_jump_prop_ff;
    logic [7:0] bt_phase_ff;
    logic [7:0] ie_high_ff;
    logic [7:0] ie_low_ff;

    wire wr_page = sfr_wr && (sfr_addr == OFS_PAGE);
    wire wr_bt1 = sfr_wr && (sfr_addr == OFS_BT_PRESCALE);
    wire wr_bt2 = sfr_wr && (sfr_addr == OFS_BT_JUMP_PROP);
    wire wr_bt3 = sfr_wr && (sfr_addr == OFS_BT_PHASE);
    wire wr_ieh = sfr_wr && (sfr_addr == OFS_IE_HIGH);
    wire wr_iel = sfr_wr && (sfr_addr == OFS_IE_LOW);

    // reserved positions are stored as zero, which is one legal undefined value
    wire [7:0] rd_mux =
        (sfr_addr == OFS_PAGE) ? page_ff :
        (sfr_addr == OFS_BT_PRESCALE) ? bt_prescale_ff :
        (sfr_addr == OFS_BT_JUMP_PROP) ? bt_jump_prop_ff :
        (sfr_addr == OFS_BT_PHASE) ? bt_phase_ff :
        (sfr_addr == OFS_IE_HIGH) ? ie_high_ff :
        (sfr_addr == OFS_IE_LOW) ? ie_low_ff : 8'h00;

    wire auto_step_n = page_ff[AUTO_STEP_BIT];
    wire [2:0] ptr_now = page_ff[PTR_MSB:PTR_LSB];
    wire step_ptr = data_access && !auto_step_n && !wr_page;
    wire [2:0] nxt_ptr = ptr_now + 3'h1;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            page_ff <= RST_PAGE;
            bt_prescale_ff <= RST_BT;
            bt_jump_prop_ff <= RST_BT;
            bt_phase_ff <= RST_BT;
            ie_high_ff <= RST_IE;
            ie_low_ff <= RST_IE;
            sfr_rdata_ff <= 8'h00;
        end
        else
        begin
            if (wr_page)
                page_ff <= sfr_wdata;
            else if (step_ptr)
                page_ff[PTR_MSB:PTR_LSB] <= nxt_ptr;
            if (wr_bt1)
                bt_prescale_ff <= sfr_wdata & MASK_BT_PRESCALE;
            if (wr_bt2)
                bt_jump_prop_ff <= sfr_wdata & MASK_BT_JUMP_PROP;
            if (wr_bt3)
                bt_phase_ff <= sfr_wdata & MASK_BT_PHASE;
            if (wr_ieh)
                ie_high_ff <= sfr_wdata & MASK_IE_HIGH;
            if (wr_iel)
                ie_low_ff <= sfr_wdata;
            if (sfr_rd)
                sfr_rdata_ff <= rd_mux;
        end
    end

    // ****************************************
    // interrupt gating and page outputs
    // ****************************************
    wire [14:0] irq_enable = {ie_high_ff[IE_HIGH_MSB:0], ie_low_ff};
    wire irq_any = |(object_irq_pending & irq_enable[NUM_OBJ-1:0]);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            controller_irq_ff <= 1'b0;
            object_number_ff <= 4'h0;
            data_byte_pointer_ff <= 3'h0;
        end
        else
        begin
            controller_irq_ff <= irq_any;
            object_number_ff <= wr_page ? sfr_wdata[OBJ_MSB:OBJ_LSB] :
                page_ff[OBJ_MSB:OBJ_LSB];
            data_byte_pointer_ff <= wr_page ? sfr_wdata[PTR_MSB:PTR_LSB] :
                step_ptr ? nxt_ptr : ptr_now;
        end
    end

    // ****************************************
    // bit timing
    // ****************************************
    logic tq_tick;
    logic half_tick;
    quantum_prescaler #(.PW(6)) u_prescaler (
        .clk(clk),
        .rst(rst),
        .run(controller_on),
        .prescale(bt_prescale_ff[PRESCALE_MSB:PRESCALE_LSB]),
        .tq_tick_ff(tq_tick),
        .half_tick_ff(half_tick)
    );
    wire [3:0] sjw_len = {2'b00, bt_jump_prop_ff[JUMP_MSB:JUMP_LSB]} + 4'h1;
    wire [3:0] prop_len = {1'b0, bt_jump_prop_ff[PROP_MSB:PROP_LSB]} + 4'h1;
    wire [3:0] ph1_base = {1'b0, bt_phase_ff[PH1_MSB:PH1_LSB]} + 4'h1;
    wire [3:0] ph2_base = {1'b0, bt_phase_ff[PH2_MSB:PH2_LSB]} + 4'h1;
    wire triple = bt_phase_ff[TRIPLE_BIT];
    seg_e seg_ff;
    seg_e nxt_seg;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic [4:0] elapsed_ff;
    logic [3:0] ph1_len_ff;
    logic [3:0] nxt_ph1_len;
    logic [3:0] ph2_len_ff;
    logic [3:0] nxt_ph2_len;
    logic resynced_ff;
    logic rx_prev_ff;
    logic [1:0] hist_ff;

    // recessive to dominant transitions are the edges that steer timing
    wire fall_edge = rx_prev_ff && !can_rx;
    wire [3:0] cnt_inc = cnt_ff + 4'h1;
    wire [3:0] ph2_left = ph2_len_ff - cnt_ff;
    wire [3:0] phase_err = (elapsed_ff > 5'h0F) ? 4'hF : elapsed_ff[3:0];
    wire [3:0] ext = (phase_err < sjw_len) ? phase_err : sjw_len;
    wire early_edge = fall_edge && !resynced_ff && (seg_ff == SEG_PROP || seg_ff == SEG_PH1);
    wire late_edge = fall_edge && !resynced_ff && (seg_ff == SEG_PH2);
    wire end_now = late_edge && (ph2_left <= sjw_len);
    wire ph1_last = tq_tick && (seg_ff == SEG_PH1) && (cnt_inc == ph1_len_ff);
    wire majority = (hist_ff[1] & hist_ff[0]) | (hist_ff[1] & can_rx) | (hist_ff[0] & can_rx);

    always_comb
    begin
        nxt_seg = seg_ff;
        nxt_cnt = cnt_ff;
        nxt_ph1_len = early_edge ? ph1_base + ext : ph1_len_ff;
        nxt_ph2_len = (late_edge && !end_now) ? ph2_len_ff - sjw_len : ph2_len_ff;
        if (end_now)
        begin
            nxt_seg = SEG_SYNC;
            nxt_cnt = 4'h0;
        end
        else if (tq_tick)
        begin
            unique case (seg_ff)
                SEG_SYNC:
                begin
                    nxt_seg = SEG_PROP;
                    nxt_cnt = 4'h0;
                    nxt_ph1_len = ph1_base;
                    nxt_ph2_len = ph2_base;
                end
                SEG_PROP:
                begin
                    nxt_seg = (cnt_inc == prop_len) ? SEG_PH1 : SEG_PROP;
                    nxt_cnt = (cnt_inc == prop_len) ? 4'h0 : cnt_inc;
                end
                SEG_PH1:
                begin
                    nxt_seg = (cnt_inc >= nxt_ph1_len) ? SEG_PH2 : SEG_PH1;
                    nxt_cnt = (cnt_inc >= nxt_ph1_len) ? 4'h0 : cnt_inc;
                end
                SEG_PH2:
                begin
                    nxt_seg = (cnt_inc >= nxt_ph2_len) ? SEG_SYNC : SEG_PH2;
                    nxt_cnt = (cnt_inc >= nxt_ph2_len) ? 4'h0 : cnt_inc;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst || !controller_on)
        begin
            seg_ff <= SEG_SYNC;
            cnt_ff <= 4'h0;
            elapsed_ff <= 5'h00;
            ph1_len_ff <= 4'h1;
            ph2_len_ff <= 4'h1;
            resynced_ff <= 1'b0;
            rx_prev_ff <= 1'b1;
            hist_ff <= 2'b11;
            sample_point_ff <= 1'b0;
            sampled_bit_ff <= 1'b1;
            bit_start_ff <= 1'b0;
        end
        else
        begin
            seg_ff <= nxt_seg;
            cnt_ff <= nxt_cnt;
            ph1_len_ff <= nxt_ph1_len;
            ph2_len_ff <= nxt_ph2_len;
            rx_prev_ff <= can_rx;
            // one resynchronisation per bit keeps the jump bounded
            resynced_ff <= (nxt_seg == SEG_SYNC) ? 1'b0 : (resynced_ff | early_edge | late_edge);
            elapsed_ff <= (seg_ff == SEG_SYNC) ? 5'h00 :
                tq_tick ? elapsed_ff + 5'h01 : elapsed_ff;
            if (half_tick || tq_tick)
                hist_ff <= {hist_ff[0], can_rx};
            sample_point_ff <= ph1_last;
            if (ph1_last)
                sampled_bit_ff <= triple ? majority : can_rx;
            bit_start_ff <= (nxt_seg == SEG_SYNC) && (seg_ff != SEG_SYNC);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_irq_gate_low: assert property (@(posedge clk) disable iff (rst)
        (irq_enable[NUM_OBJ-1:0] == '0) |=> !controller_irq_ff)
        else $error("interrupt raised with all enables clear");
    a_ie_high_rsvd: assert property (@(posedge clk) disable iff (rst)
        wr_ieh |=> (ie_high_ff == (($past(sfr_wdata)) & 8'h7F)))
        else $error("high enable byte not stored in bits 6-0");
    a_bt_readback: assert property (@(posedge clk) disable iff (rst)
        (wr_bt3 ##1 !wr_bt3 ##1 (sfr_rd && sfr_addr == OFS_BT_PHASE && !sfr_wr))
        |=> (sfr_rdata_ff == ($past(sfr_wdata, 3) & 8'h7F)))
        else $error("phase register read differs from write");
    a_ptr_steps: assert property (@(posedge clk) disable iff (rst)
        step_ptr |=> (page_ff[PTR_MSB:PTR_LSB] == $past(ptr_now) + 3'h1))
        else $error("byte pointer did not advance");
    a_ptr_holds: assert property (@(posedge clk) disable iff (rst)
        (data_access && auto_step_n && !wr_page) |=> $stable(page_ff[PTR_MSB:PTR_LSB]))
        else $error("byte pointer moved with auto step off");
    a_obj_select: assert property (@(posedge clk) disable iff (rst)
        wr_page |=> (object_number_ff == $past(sfr_wdata[OBJ_MSB:OBJ_LSB])))
        else $error("object number output not updated");
    a_sample_ph1: assert property (@(posedge clk) disable iff (rst || !controller_on)
        sample_point_ff |-> $past(seg_ff == SEG_PH1))
        else $error("sample point outside phase one");
    a_single_sample: assert property (@(posedge clk) disable iff (rst || !controller_on)
        (ph1_last && !triple) |=> (sampled_bit_ff == $past(can_rx)))
        else $error("single sample mismatch");
    a_sync_one_tq: assert property (@(posedge clk) disable iff (rst || !controller_on)
        (seg_ff == SEG_SYNC && tq_tick) |=> (seg_ff == SEG_PROP && cnt_ff == 4'h0))
        else $error("sync segment not one quantum");
    a_prop_len: assert property (@(posedge clk) disable iff (rst || !controller_on)
        (seg_ff == SEG_PROP && tq_tick && !end_now) |=>
        (seg_ff == SEG_PH1) == ($past(cnt_inc) == $past(prop_len)))
        else $error("propagation segment length wrong");
endmodule

// ===== testbench/can_far_node.sv
// far-side can node: pulls the bus dominant on request, else leaves it recessive
// assumes a recessive pull-up on the bus, so an idle node shows 1
`timescale 1ns/10ps
module can_far_node
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the bench
    input wire logic dominant_req,
    // bus level seen by the controller
    output logic bus_level_ff
);
    // level moves only after an edge, as a transceiver output would
    always_ff @(posedge clk)
    begin
        if (rst)
            bus_level_ff <= 1'b1;
        else
            bus_level_ff <= ~dominant_req;
    end
endmodule

// ===== testbench/can_timing_config_tb_top.sv
// self-checking bench for the can configuration block
// assumes the package and the far node model are compiled before this file
`timescale 1ns/10ps
module can_timing_config_tb_top
    import can_cfg_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata_ff;
    logic controller_on = 1'b0;
    logic [14:0] object_irq_pending = 15'h0000;
    logic data_access = 1'b0;
    logic controller_irq_ff;
    logic [3:0] object_number_ff;
    logic [2:0] data_byte_pointer_ff;
    logic can_rx;
    logic sample_point_ff;
    logic sampled_bit_ff;
    logic bit_start_ff;
    logic dominant_req = 1'b0;
    int bad_count = 0;
    int n_checks = 0;
    logic [7:0] addrs [6] = '{8'hB1, 8'hB4, 8'hB5, 8'hB6, 8'hC2, 8'hC3};
    // writable bits only: reserved positions are never set
    logic [7:0] masks [6] = '{8'hFF, 8'h7E, 8'h6E, 8'h7F, 8'h7F, 8'hFF};
    logic [7:0] cfg1 [3] = '{8'h02, 8'h00, 8'h7E};
    logic [7:0] cfg2 [3] = '{8'h00, 8'h64, 8'h00};
    logic [7:0] cfg3 [3] = '{8'h10, 8'h66, 8'h10};
    int cfg_len [3] = '{10, 15, 320};

    always #2 clk = ~clk;

    can_timing_config #(.NUM_OBJ(15)) i_can_timing_config (
        .clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata_ff(sfr_rdata_ff), .controller_on(controller_on),
        .object_irq_pending(object_irq_pending), .data_access(data_access),
        .controller_irq_ff(controller_irq_ff), .object_number_ff(object_number_ff),
        .data_byte_pointer_ff(data_byte_pointer_ff), .can_rx(can_rx),
        .sample_point_ff(sample_point_ff), .sampled_bit_ff(sampled_bit_ff),
        .bit_start_ff(bit_start_ff)
    );

    can_far_node i_can_far_node (
        .clk(clk), .rst(rst), .dominant_req(dominant_req), .bus_level_ff(can_rx)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(input string what, input int exp, input int got);
        n_checks++;
        if (got != exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        sfr_addr <= addr;
        sfr_wdata <= data;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk);
        sfr_addr <= addr;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        #1;
        data = sfr_rdata_ff;
    endtask

    task automatic step_ptr();
        @(posedge clk);
        data_access <= 1'b1;
        @(posedge clk);
        data_access <= 1'b0;
        #1;
    endtask

    task automatic wait_sample();
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (sample_point_ff !== 1'b1 && k < 400);
        @(posedge clk);
        #1;
    endtask

    // clocks between two bit starts; drop pulls the bus low just after the sample point
    task automatic bit_period(input logic drop, output int n);
        int k;
        logic seen;
        k = 0;
        seen = 1'b0;
        while (bit_start_ff !== 1'b1 && k < 400)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        n = 0;
        do
        begin
            @(posedge clk);
            if (drop && seen)
                dominant_req <= 1'b1;
            #1;
            seen = (sample_point_ff === 1'b1);
            n++;
        end
        while (bit_start_ff !== 1'b1 && n < 400);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        logic [7:0] rd;
        int n;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (addrs[i])
        begin
            reg_rd(addrs[i], rd);
            check8("reset value", 8'h00, rd);
        end
        foreach (addrs[i])
        begin
            reg_wr(addrs[i], 8'hAA & masks[i]);
            reg_rd(addrs[i], rd);
            check8("readback", 8'hAA & masks[i], rd);
            reg_wr(addrs[i], 8'h55 & masks[i]);
            reg_rd(addrs[i], rd);
            check8("readback", 8'h55 & masks[i], rd);
        end
        reg_wr(8'hB0, 8'hFF);
        reg_rd(8'hB0, rd);
        check8("unmapped read", 8'h00, rd);
        $display("test registers done");

        reg_wr(OFS_IE_HIGH, 8'h0C);
        reg_wr(OFS_IE_LOW, 8'h0C);
        for (int i = 0; i < 15; i++)
        begin
            @(posedge clk);
            object_irq_pending <= 15'h0001 << i;
            repeat (2) @(posedge clk);
            #1;
            check8("irq", {7'h00, 1'(15'h0C0C >> i)}, {7'h00, controller_irq_ff});
        end
        @(posedge clk);
        object_irq_pending <= 15'h0000;
        $display("test interrupt enables done");

        reg_wr(OFS_PAGE, 8'h35);
        check8("object", 8'h03, {4'h0, object_number_ff});
        check8("pointer", 8'h05, {5'h00, data_byte_pointer_ff});
        for (int i = 6; i < 9; i++)
        begin
            step_ptr();
            check8("pointer step", 8'(i % 8), {5'h00, data_byte_pointer_ff});
        end
        reg_wr(OFS_PAGE, 8'hEA);
        step_ptr();
        check8("object", 8'h0E, {4'h0, object_number_ff});
        check8("pointer held", 8'h02, {5'h00, data_byte_pointer_ff});
        $display("test page select done");

        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk);
            controller_on <= 1'b0;
            reg_wr(OFS_BT_PRESCALE, cfg1[i]);
            reg_wr(OFS_BT_JUMP_PROP, cfg2[i]);
            reg_wr(OFS_BT_PHASE, cfg3[i]);
            @(posedge clk);
            controller_on <= 1'b1;
            bit_period(1'b0, n);
            check_count("bit period", cfg_len[i], n);
        end
        $display("test bit length done");

        for (int j = 0; j < 2; j++)
        begin
            @(posedge clk);
            controller_on <= 1'b0;
            dominant_req <= 1'b0;
            reg_wr(OFS_BT_PRESCALE, 8'h00);
            reg_wr(OFS_BT_JUMP_PROP, 8'(j << 5));
            reg_wr(OFS_BT_PHASE, 8'h70);
            @(posedge clk);
            controller_on <= 1'b1;
            bit_period(1'b1, n);
            check_count("shortened bit", 10 - j, n);
            wait_sample();
            check8("sampled level", 8'h00, {7'h00, sampled_bit_ff});
        end
        $display("test resync done");

        @(posedge clk);
        controller_on <= 1'b0;
        dominant_req <= 1'b0;
        reg_wr(OFS_BT_PRESCALE, 8'h06);
        reg_wr(OFS_BT_PHASE, 8'h71);
        @(posedge clk);
        controller_on <= 1'b1;
        wait_sample();
        wait_sample();
        check8("triple sample", 8'h01, {7'h00, sampled_bit_ff});
        @(posedge clk);
        dominant_req <= 1'b1;
        wait_sample();
        wait_sample();
        check8("triple sample", 8'h00, {7'h00, sampled_bit_ff});
        // one-clock dominant glitch at the sample point: majority must outvote it
        @(posedge clk);
        dominant_req <= 1'b0;
        wait_sample();
        repeat (41) @(posedge clk);
        dominant_req <= 1'b1;
        @(posedge clk);
        dominant_req <= 1'b0;
        @(posedge clk);
        #1;
        check8("glitch sample point", 8'h01, {7'h00, sample_point_ff});
        check8("triple majority", 8'h01, {7'h00, sampled_bit_ff});
        $display("test triple sampling done");
        tally_and_finish();
    end

    // far beyond the roughly 1150 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        tally_and_finish();
    end
endmodule
